// ### rtl/oli_consts.vh
// Register map, field positions, reset values and codes of the overtravel limit inhibit.
`ifndef OLI_CONSTS_VH
`define OLI_CONSTS_VH
`define OLI_ADDR_CTRL 8'h00
`define OLI_ADDR_QSTOP 8'h04
`define OLI_ADDR_STATUS 8'h08
`define OLI_ADDR_INT_STAT 8'h0C
`define OLI_ADDR_INT_CLR 8'h10
`define OLI_ADDR_INT_EN 8'h14
`define OLI_ADDR_INSEL_BASE 8'h40
`define OLI_ADDR_INSEL_LAST 8'h64
`define OLI_NUM_TERM 10
`define OLI_CTRL_MODE_LSB 0
`define OLI_CTRL_METHOD_LSB 8
`define OLI_CTRL_ALMRST_BIT 16
`define OLI_MODE_RST 2'h1
`define OLI_METHOD_RST 2'h0
`define OLI_QSTOP_RST 16'h0000
`define OLI_INSEL_FIRST_RST 24'h828282
`define OLI_INSEL_SECOND_RST 24'h818181
`define OLI_INSEL_OTHER_RST 24'h000000
`define OLI_FN_FWD 7'h01
`define OLI_FN_REV 7'h02
`define OLI_FN_NC_BIT 7
`define OLI_EN_ON_SINGLE 2'h0
`define OLI_EN_OFF 2'h1
`define OLI_EN_ALARM_ANY 2'h2
`define OLI_STOP_DBRAKE 2'h0
`define OLI_STOP_FREERUN 2'h1
`define OLI_STOP_IMMEDIATE 2'h2
`define OLI_STAT_FWD_BIT 0
`define OLI_STAT_REV_BIT 1
`define OLI_STAT_ALARM_BIT 2
`define OLI_STAT_FWD_RAW_BIT 3
`define OLI_STAT_REV_RAW_BIT 4
`define OLI_STAT_STATE_LSB 5
`define OLI_IRQ_FWD 0
`define OLI_IRQ_REV 1
`define OLI_IRQ_ALARM 2
`define OLI_IRQ_STOPPED 3
`define OLI_IRQ_W 4
`endif

// ### rtl/oli_overtravel_inhibit.v
// Overtravel limit inhibit with input allocation, stop sequencing and an APB register file.
`timescale 1ns/1ps
`include "oli_consts.vh"
module oli_overtravel_inhibit (
  input wire clock,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [9:0] termIn,
  input wire [1:0] ctrlMode,
  input wire motorStopped,
  output reg fwdInhibit_ff,
  output reg revInhibit_ff,
  output reg limitAlarm_ff,
  output reg dynBrake_ff,
  output reg torqueZeroFwd_ff,
  output reg torqueZeroRev_ff,
  output reg servoLock_ff,
  output reg errClear_ff,
  output reg torqueLimitEn_ff,
  output reg [15:0] torqueLimit_ff,
  output reg irq_ff
);

  // Stop sequencer states.
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_DECEL = 2'h1;
  localparam [1:0] ST_HOLD = 2'h2;

  // Picks the function byte that applies to the present control mode.
  function [7:0] selByte;
    input [23:0] sel;
    input [1:0] mode;
    begin
      case (mode)
        2'h1: selByte = sel[15:8];
        2'h2: selByte = sel[23:16];
        default: selByte = sel[7:0];
      endcase
    end
  endfunction

  // Live setting while idle, frozen copy once a stop sequence has started.
  function [1:0] seqMethod;
    input [1:0] st;
    input [1:0] liveMethod;
    input [1:0] heldMethod;
    begin
      if (st == ST_IDLE) begin
        seqMethod = liveMethod;
      end else begin
        seqMethod = heldMethod;
      end
    end
  endfunction

  reg [1:0] enableMode_ff;
  reg [1:0] stopMethod_ff;
  reg [1:0] runMethod_ff;
  reg [15:0] quickStop_ff;
  reg [23:0] inSel_ff [0:`OLI_NUM_TERM-1];
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [`OLI_IRQ_W-1:0] intStat_ff;
  reg [`OLI_IRQ_W-1:0] intEn_ff;
  reg [`OLI_IRQ_W-1:0] nxt_intStat;
  reg [31:0] nxt_prdata;
  reg nxt_slverr;
  wire [9:0] fwdHit;
  wire [9:0] revHit;
  wire fwdActive;
  wire revActive;
  wire limitsOn;
  wire alarmCause;
  wire nxt_fwdInh;
  wire nxt_revInh;
  wire nxt_alarm;
  wire busDone;
  wire wrDone;
  wire almRstReq;
  wire [3:0] selIdx;
  wire selHit;
  reg seqErrClear;
  reg stopDone;
  wire [1:0] curMethod;

  // Each terminal is decoded on its own, so any pin may carry either limit in either logic.
  genvar gi;
  generate
    for (gi = 0; gi < `OLI_NUM_TERM; gi = gi + 1) begin : gTerm
      wire [7:0] fn = selByte(inSel_ff[gi], ctrlMode);
      wire act = fn[`OLI_FN_NC_BIT] ? ~termIn[gi] : termIn[gi];
      assign fwdHit[gi] = (fn[6:0] == `OLI_FN_FWD) & act;
      assign revHit[gi] = (fn[6:0] == `OLI_FN_REV) & act;
    end
  endgenerate

  assign fwdActive = |fwdHit;
  assign revActive = |revHit;
  // A mode of 3 is treated like mode 1 so a bad setting never blocks motion unexpectedly.
  assign limitsOn = (enableMode_ff == `OLI_EN_ON_SINGLE) || (enableMode_ff == `OLI_EN_ALARM_ANY);
  assign alarmCause = ((enableMode_ff == `OLI_EN_ON_SINGLE) && fwdActive && revActive) ||
    ((enableMode_ff == `OLI_EN_ALARM_ANY) && (fwdActive || revActive));

  assign busDone = psel & penable & pready;
  assign wrDone = busDone & pwrite;
  assign almRstReq = wrDone && (paddr == `OLI_ADDR_CTRL) && pwdata[`OLI_CTRL_ALMRST_BIT];
  assign selHit = (paddr >= `OLI_ADDR_INSEL_BASE) && (paddr <= `OLI_ADDR_INSEL_LAST) &&
    (paddr[1:0] == 2'h0);
  assign selIdx = paddr[5:2];

  // The alarm stays latched until software resets it with the cause gone.
  assign nxt_alarm = alarmCause | (limitAlarm_ff & ~almRstReq);
  // A latched alarm freezes an inhibit, so a bouncing switch cannot restart motion.
  assign nxt_fwdInh = limitsOn & (fwdActive | (fwdInhibit_ff & limitAlarm_ff));
  assign nxt_revInh = limitsOn & (revActive | (revInhibit_ff & limitAlarm_ff));

  // Method that governs the outputs computed at this edge.
  assign curMethod = seqMethod(state_ff, stopMethod_ff, runMethod_ff);

  // Stop sequence state.
  always @* begin
    nxt_state = state_ff;
    seqErrClear = 1'b0;
    stopDone = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (nxt_fwdInh | nxt_revInh) begin
          nxt_state = ST_DECEL;
          seqErrClear = (stopMethod_ff == `OLI_STOP_IMMEDIATE);
        end
      end
      ST_DECEL: begin
        if (!(nxt_fwdInh | nxt_revInh)) begin
          nxt_state = ST_IDLE;
        end else if (motorStopped) begin
          nxt_state = ST_HOLD;
          stopDone = 1'b1;
          seqErrClear = (runMethod_ff == `OLI_STOP_IMMEDIATE);
        end
      end
      ST_HOLD: begin
        if (!(nxt_fwdInh | nxt_revInh)) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Sticky events; a new event beats a clear in the same cycle.
  always @* begin
    nxt_intStat = intStat_ff;
    if (wrDone && (paddr == `OLI_ADDR_INT_CLR)) begin
      nxt_intStat = intStat_ff & ~pwdata[`OLI_IRQ_W-1:0];
    end
    if (nxt_fwdInh & ~fwdInhibit_ff) begin
      nxt_intStat[`OLI_IRQ_FWD] = 1'b1;
    end
    if (nxt_revInh & ~revInhibit_ff) begin
      nxt_intStat[`OLI_IRQ_REV] = 1'b1;
    end
    if (nxt_alarm & ~limitAlarm_ff) begin
      nxt_intStat[`OLI_IRQ_ALARM] = 1'b1;
    end
    if (stopDone) begin
      nxt_intStat[`OLI_IRQ_STOPPED] = 1'b1;
    end
  end

  // Read mux; unmapped addresses and reads of the clear register answer with an error.
  always @* begin
    nxt_prdata = 32'h00000000;
    nxt_slverr = 1'b0;
    if (selHit) begin
      nxt_prdata = {8'h00, inSel_ff[selIdx]};
    end else begin
      case (paddr)
        `OLI_ADDR_CTRL: begin
          nxt_prdata[`OLI_CTRL_MODE_LSB+1:`OLI_CTRL_MODE_LSB] = enableMode_ff;
          nxt_prdata[`OLI_CTRL_METHOD_LSB+1:`OLI_CTRL_METHOD_LSB] = stopMethod_ff;
        end
        `OLI_ADDR_QSTOP: nxt_prdata = {16'h0000, quickStop_ff};
        `OLI_ADDR_STATUS: begin
          nxt_prdata[`OLI_STAT_FWD_BIT] = fwdInhibit_ff;
          nxt_prdata[`OLI_STAT_REV_BIT] = revInhibit_ff;
          nxt_prdata[`OLI_STAT_ALARM_BIT] = limitAlarm_ff;
          nxt_prdata[`OLI_STAT_FWD_RAW_BIT] = fwdActive;
          nxt_prdata[`OLI_STAT_REV_RAW_BIT] = revActive;
          nxt_prdata[`OLI_STAT_STATE_LSB+1:`OLI_STAT_STATE_LSB] = state_ff;
        end
        `OLI_ADDR_INT_STAT: nxt_prdata = {28'h0000000, intStat_ff};
        `OLI_ADDR_INT_EN: nxt_prdata = {28'h0000000, intEn_ff};
        `OLI_ADDR_INT_CLR: nxt_slverr = ~pwrite;
        default: nxt_slverr = 1'b1;
      endcase
    end
  end

  // APB answer: one wait state, so pready rises in the second access cycle.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & nxt_slverr;
      prdata <= (psel & penable & ~pready & ~pwrite) ? nxt_prdata : 32'h00000000;
    end
  end

  // Software registers; writes take effect at the completing edge only.
  integer k;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      enableMode_ff <= `OLI_MODE_RST;
      stopMethod_ff <= `OLI_METHOD_RST;
      quickStop_ff <= `OLI_QSTOP_RST;
      intEn_ff <= {`OLI_IRQ_W{1'b0}};
      for (k = 0; k < `OLI_NUM_TERM; k = k + 1) begin
        inSel_ff[k] <= `OLI_INSEL_OTHER_RST;
      end
      inSel_ff[0] <= `OLI_INSEL_FIRST_RST;
      inSel_ff[1] <= `OLI_INSEL_SECOND_RST;
    end else if (wrDone) begin
      if (selHit) begin
        inSel_ff[selIdx] <= pwdata[23:0];
      end
      case (paddr)
        `OLI_ADDR_CTRL: begin
          enableMode_ff <= pwdata[`OLI_CTRL_MODE_LSB+1:`OLI_CTRL_MODE_LSB];
          stopMethod_ff <= pwdata[`OLI_CTRL_METHOD_LSB+1:`OLI_CTRL_METHOD_LSB];
        end
        `OLI_ADDR_QSTOP: quickStop_ff <= pwdata[15:0];
        `OLI_ADDR_INT_EN: intEn_ff <= pwdata[`OLI_IRQ_W-1:0];
        default: intEn_ff <= intEn_ff;
      endcase
    end
  end

  // Limit evaluation and stop outputs, updated every control cycle.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      runMethod_ff <= `OLI_STOP_DBRAKE;
      fwdInhibit_ff <= 1'b0;
      revInhibit_ff <= 1'b0;
      limitAlarm_ff <= 1'b0;
      dynBrake_ff <= 1'b0;
      torqueZeroFwd_ff <= 1'b0;
      torqueZeroRev_ff <= 1'b0;
      servoLock_ff <= 1'b0;
      errClear_ff <= 1'b0;
      torqueLimitEn_ff <= 1'b0;
      torqueLimit_ff <= 16'h0000;
      intStat_ff <= {`OLI_IRQ_W{1'b0}};
      irq_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      // The method is frozen at entry so a setting change cannot mix two sequences.
      if (state_ff == ST_IDLE) begin
        runMethod_ff <= stopMethod_ff;
      end
      fwdInhibit_ff <= nxt_fwdInh;
      revInhibit_ff <= nxt_revInh;
      limitAlarm_ff <= nxt_alarm;
      dynBrake_ff <= (nxt_state == ST_DECEL) && (curMethod == `OLI_STOP_DBRAKE);
      torqueZeroFwd_ff <= nxt_fwdInh && (nxt_state != ST_IDLE) &&
        (curMethod != `OLI_STOP_IMMEDIATE) &&
        ((nxt_state == ST_HOLD) || (curMethod == `OLI_STOP_FREERUN));
      torqueZeroRev_ff <= nxt_revInh && (nxt_state != ST_IDLE) &&
        (curMethod != `OLI_STOP_IMMEDIATE) &&
        ((nxt_state == ST_HOLD) || (curMethod == `OLI_STOP_FREERUN));
      servoLock_ff <= (nxt_state == ST_HOLD) && (runMethod_ff == `OLI_STOP_IMMEDIATE);
      errClear_ff <= seqErrClear;
      torqueLimitEn_ff <= (nxt_state == ST_DECEL) && (curMethod == `OLI_STOP_IMMEDIATE);
      torqueLimit_ff <= quickStop_ff;
      intStat_ff <= nxt_intStat;
      irq_ff <= |(nxt_intStat & intEn_ff);
    end
  end

endmodule

// ### verif/oli_properties.sv
// Port-level checks of the overtravel limit inhibit.
`timescale 1ns/1ps
module oli_properties (
  input logic clock,
  input logic rst_n,
  input logic psel,
  input logic penable,
  input logic pready,
  input logic pslverr,
  input logic motorStopped,
  input logic fwdInhibit_ff,
  input logic revInhibit_ff,
  input logic limitAlarm_ff,
  input logic dynBrake_ff,
  input logic torqueZeroFwd_ff,
  input logic servoLock_ff,
  input logic errClear_ff,
  input logic torqueLimitEn_ff
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  AST_READY_CAUSE: assert property (pready |-> $past(psel && penable))
    else $error("pready without an access phase");
  AST_ERR_PAIRED: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_ALARM_BLOCKS: assert property ($rose(limitAlarm_ff) |-> fwdInhibit_ff || revInhibit_ff)
    else $error("alarm raised with no direction blocked");
  AST_BRAKE_BLOCKED: assert property (dynBrake_ff |-> (fwdInhibit_ff || revInhibit_ff ||
    $past(fwdInhibit_ff || revInhibit_ff)) && !servoLock_ff)
    else $error("dynamic brake without a blocked direction");
  AST_ZERO_FWD: assert property (torqueZeroFwd_ff |-> fwdInhibit_ff || $past(fwdInhibit_ff))
    else $error("forward torque zeroed while forward is free");
  AST_CLEAR_PULSE: assert property (errClear_ff |=> !errClear_ff)
    else $error("error clear longer than one cycle");
  AST_CAP_START: assert property ($rose(torqueLimitEn_ff) |-> errClear_ff && !dynBrake_ff)
    else $error("torque cap started without counter clear");
  AST_LOCK_AFTER_STOP: assert property ($rose(servoLock_ff) |->
    $past(motorStopped) && errClear_ff && !torqueLimitEn_ff)
    else $error("servo lock not tied to standstill and clear");
  AST_RELEASE: assert property ((!fwdInhibit_ff && !revInhibit_ff) [*2] |->
    !dynBrake_ff && !servoLock_ff && !torqueLimitEn_ff)
    else $error("stop sequence active with no inhibit");
endmodule
bind oli_overtravel_inhibit oli_properties chk (.clock(clock), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .motorStopped(motorStopped),
  .fwdInhibit_ff(fwdInhibit_ff), .revInhibit_ff(revInhibit_ff), .limitAlarm_ff(limitAlarm_ff),
  .dynBrake_ff(dynBrake_ff), .torqueZeroFwd_ff(torqueZeroFwd_ff), .servoLock_ff(servoLock_ff),
  .errClear_ff(errClear_ff), .torqueLimitEn_ff(torqueLimitEn_ff));

// ### verif/oli_far_side.sv
// Limit switches and host motion controller facing the inhibit block.
`timescale 1ns/1ps
module oli_far_side (
  input logic clock,
  input logic rst_n,
  input logic [9:0] contactClosed,
  input logic [7:0] stopDelay,
  input logic inhibitSeen,
  output logic [9:0] termIn,
  output logic motorStopped
);
  logic [7:0] count_ff;
  // Contacts are wired straight to the terminals; a closed contact reads 1.
  assign termIn = contactClosed;
  // Host keeps following error and overtravel levels wide enough for hard stops.
  // Vertical axes are restricted by the host itself, so a slow coast is harmless here.
  // The axis comes to rest stopDelay+1 cycles after it sees an inhibit, so prompt and slow stops both occur.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= 8'h00;
      motorStopped <= 1'b0;
    end else if (!inhibitSeen) begin
      count_ff <= 8'h00;
      motorStopped <= 1'b0;
    end else if (count_ff >= stopDelay) begin
      motorStopped <= 1'b1;
    end else begin
      count_ff <= count_ff + 8'h01;
    end
  end
endmodule

// ### verif/oli_testbench.sv
// Directed register and limit-switch tests of the overtravel limit inhibit.
`timescale 1ns/1ps
module testbench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [9:0] contacts = 10'h3FF;
  logic [1:0] ctrlMode = 2'h0;
  logic [7:0] stopDelay = 8'h01;
  logic [31:0] rd;
  logic err;
  integer mismatches = 0;
  integer checks = 0;
  integer clears = 0;
  integer c0;
  wire [31:0] prdata;
  wire [15:0] torqueLimit_ff;
  wire [9:0] termIn;
  wire pready, pslverr, motorStopped, irq_ff, fwdInhibit_ff, revInhibit_ff, limitAlarm_ff;
  wire dynBrake_ff, torqueZeroFwd_ff, torqueZeroRev_ff, servoLock_ff, errClear_ff;
  wire torqueLimitEn_ff;
  wire [7:0] outs = {fwdInhibit_ff, revInhibit_ff, limitAlarm_ff, dynBrake_ff,
    torqueZeroFwd_ff, torqueZeroRev_ff, servoLock_ff, torqueLimitEn_ff};
  always #5 clock = ~clock;
  always @(posedge clock) if (errClear_ff === 1'b1) clears <= clears + 1;
  oli_overtravel_inhibit dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .termIn(termIn), .ctrlMode(ctrlMode), .motorStopped(motorStopped),
    .fwdInhibit_ff(fwdInhibit_ff), .revInhibit_ff(revInhibit_ff), .limitAlarm_ff(limitAlarm_ff),
    .dynBrake_ff(dynBrake_ff), .torqueZeroFwd_ff(torqueZeroFwd_ff),
    .torqueZeroRev_ff(torqueZeroRev_ff), .servoLock_ff(servoLock_ff), .errClear_ff(errClear_ff),
    .torqueLimitEn_ff(torqueLimitEn_ff), .torqueLimit_ff(torqueLimit_ff), .irq_ff(irq_ff));
  oli_far_side partner (.clock(clock), .rst_n(rst_n), .contactClosed(contacts),
    .stopDelay(stopDelay), .inhibitSeen(fwdInhibit_ff | revInhibit_ff), .termIn(termIn),
    .motorStopped(motorStopped));
  task cyc(input integer n);
    repeat (n) @(posedge clock);
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cmp_out(input logic [7:0] m, input logic [7:0] e);
    cmp({24'h0, outs & m}, {24'h0, e});
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
        @(posedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e, input logic x);
    begin
      apb(1'b0, a, 32'h0);
      cmp(rd, e);
      cmp({31'h0, err}, {31'h0, x});
    end
  endtask
  task wait_stop;
    integer n;
    begin
      n = 0;
      while (motorStopped !== 1'b1 && n < 200) begin
        @(posedge clock);
        n = n + 1;
      end
      cyc(2);
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  // The whole sequence needs well under two thousand cycles.
  initial begin
    cyc(20000);
    mismatches = mismatches + 1;
    wrap_up;
  end
  initial begin
    cyc(16);
    rst_n <= 1'b1;
    cyc(1);
    rdc(8'h00, 32'h1, 1'b0);
    rdc(8'h40, 32'h00828282, 1'b0);
    rdc(8'h44, 32'h00818181, 1'b0);
    rdc(8'h20, 32'h0, 1'b1);
    rdc(8'h10, 32'h0, 1'b1);
    contacts <= 10'h000;
    cyc(3);
    cmp_out(8'hFF, 8'h00);
    contacts <= 10'h3FF;
    wr(8'h14, 32'hF);
    rdc(8'h14, 32'hF, 1'b0);
    wr(8'h00, 32'h000);
    contacts <= 10'h3FD;
    cyc(2);
    cmp_out(8'hFF, 8'h90);
    wait_stop;
    cmp_out(8'hFF, 8'h88);
    rdc(8'h08, 32'h49, 1'b0);
    cmp({31'h0, irq_ff}, 32'h1);
    contacts <= 10'h3FF;
    cyc(2);
    cmp_out(8'hFF, 8'h00);
    rdc(8'h0C, 32'h9, 1'b0);
    wr(8'h10, 32'hF);
    rdc(8'h0C, 32'h0, 1'b0);
    cmp({31'h0, irq_ff}, 32'h0);
    stopDelay <= 8'h14;
    wr(8'h00, 32'h100);
    contacts <= 10'h3FE;
    cyc(2);
    cmp_out(8'hFF, 8'h44);
    wait_stop;
    cmp_out(8'hFF, 8'h44);
    contacts <= 10'h3FF;
    cyc(2);
    rdc(8'h0C, 32'hA, 1'b0);
    wr(8'h10, 32'hF);
    wr(8'h14, 32'h0);
    contacts <= 10'h3FE;
    cyc(4);
    cmp({31'h0, irq_ff}, 32'h0);
    rdc(8'h0C, 32'h2, 1'b0);
    contacts <= 10'h3FF;
    stopDelay <= 8'h01;
    wr(8'h04, 32'h1234);
    rdc(8'h04, 32'h1234, 1'b0);
    wr(8'h00, 32'h200);
    c0 = clears;
    contacts <= 10'h3FD;
    cyc(2);
    cmp_out(8'hFF, 8'h81);
    cmp({16'h0, torqueLimit_ff}, 32'h1234);
    wait_stop;
    cmp_out(8'hFF, 8'h82);
    cmp(clears - c0, 32'h2);
    contacts <= 10'h3FF;
    cyc(2);
    cmp_out(8'hFF, 8'h00);
    contacts <= 10'h3FC;
    cyc(2);
    cmp_out(8'hE0, 8'hE0);
    contacts <= 10'h3FF;
    cyc(3);
    cmp_out(8'hE0, 8'hE0);
    wr(8'h00, 32'h10200);
    cyc(2);
    cmp_out(8'hE0, 8'h00);
    wr(8'h00, 32'h2);
    contacts <= 10'h3FD;
    cyc(2);
    cmp_out(8'hE0, 8'hA0);
    contacts <= 10'h3FF;
    wr(8'h00, 32'h10002);
    cyc(2);
    cmp_out(8'hE0, 8'h00);
    wr(8'h44, 32'h0);
    wr(8'h48, 32'h100);
    wr(8'h00, 32'h0);
    cyc(2);
    cmp_out(8'h80, 8'h00);
    ctrlMode <= 2'h1;
    cyc(2);
    cmp_out(8'h80, 8'h80);
    ctrlMode <= 2'h2;
    cyc(2);
    cmp_out(8'h80, 8'h00);
    ctrlMode <= 2'h3;
    cyc(2);
    cmp_out(8'h80, 8'h00);
    wr(8'h00, 32'h3);
    contacts <= 10'h000;
    cyc(3);
    cmp_out(8'hFF, 8'h00);
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(1);
    rdc(8'h44, 32'h00818181, 1'b0);
    rdc(8'h00, 32'h1, 1'b0);
    cmp_out(8'hFF, 8'h00);
    wrap_up;
  end
endmodule
